// ===== src/iem_pkg.sv
// Package: register map, field layout and types of the interrupt enable manager
package iem_pkg;
    localparam logic [6:0]  ADDR_PRIMARY_EN   = 7'h02;
    localparam logic [6:0]  ADDR_SECONDARY_EN = 7'h03;
    localparam logic [6:0]  ADDR_MANAGEMENT   = 7'h04;
    localparam logic [6:0]  ADDR_STATUS       = 7'h01;
    localparam logic [6:0]  ADDR_R_INTERVAL   = 7'h25;
    // Flag positions within status bits 23:8
    localparam int          BIT_FAST          = 21;
    localparam int          BIT_LEADOFF       = 20;
    localparam int          BIT_LEADSON       = 11;
    localparam int          BIT_REVENT        = 10;
    localparam int          BIT_SYNC          = 9;
    localparam int          BIT_PLL           = 8;
    localparam logic [23:0] EN_MASK           = 24'hF00F03;
    localparam logic [23:0] MNG_MASK          = 24'h000077;
    localparam logic [23:0] EN_RESET          = 24'h000003;
    localparam logic [23:0] MNG_RESET         = 24'h000004;
    localparam int          POS_TYPE          = 0;
    localparam int          POS_SYNC_RATE     = 0;
    localparam int          POS_SYNC_CLR      = 2;
    localparam int          POS_REV_CLR       = 4;
    localparam int          POS_FAST_CLR      = 6;
    localparam int          TRANSFER_EDGES    = 32;
    // Self-clear spans in master clocks, defaults for a shortened data rate
    localparam int          DATA_RATE_CYCLES  = 64;
    localparam int          QUARTER_CYCLES    = DATA_RATE_CYCLES / 4;

    typedef enum logic [1:0] {DRV_OFF, DRV_PUSH, DRV_OD, DRV_OD_PULL} iem_drv_e;

    typedef struct packed {
        logic oe;
        logic out;
        logic pull;
    } iem_pin_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [23:0] data;
    } iem_xfer_s;
endpackage : iem_pkg

// ===== src/iem_pin_driver.sv
// Module: active-low interrupt pin driver with selectable output type
`timescale 1ns/1ps
module iem_pin_driver (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               request,
    input  wire logic [1:0]         driverType,
    output iem_pkg::iem_pin_s       pin
);
    iem_pkg::iem_pin_s next_pin;
    wire logic active = request;
    always_comb begin
        next_pin = '{oe: 1'b0, out: 1'b1, pull: 1'b0};
        case (iem_pkg::iem_drv_e'(driverType))
            iem_pkg::DRV_OFF:     next_pin = '{oe: 1'b0, out: 1'b1, pull: 1'b0};
            iem_pkg::DRV_PUSH:    next_pin = '{oe: 1'b1, out: ~active, pull: 1'b0};
            iem_pkg::DRV_OD:      next_pin = '{oe: active, out: 1'b0, pull: 1'b0};
            iem_pkg::DRV_OD_PULL: next_pin = '{oe: active, out: 1'b0, pull: 1'b1};
            default:              next_pin = '{oe: 1'b0, out: 1'b1, pull: 1'b0};
        endcase
    end
    // Registered so the pin never glitches while flags and enables settle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin <= '{oe: 1'b0, out: 1'b1, pull: 1'b1};
        end else begin
            pin <= next_pin;
        end
    end
endmodule : iem_pin_driver

// ===== src/iem_manager.sv
// Module: interrupt enable, flag clearing and sample-sync management
`timescale 1ns/1ps
// Summary of operation
// - Each interrupt pin is the OR of flags enabled in its own register.
// - Register 0x02 steers the primary pin, 0x03 the secondary pin.
// - Enable bit positions match status bits 23 to 8.
// - All enable bits are zero after reset.
// - Bits 1:0 pick off, push-pull, open-drain or pulled open-drain; default 11.
// - Both pins are active low in every driver type except off, which never drives them.
// - Masking an enable hides a flag but leaves the condition intact.
// - Clear mode 0 holds fast flag while engaged, then until status read.
// - Clear mode 1 lets status read clear it; re-arm only on re-entry.
// - Read-clear flags clear at the 32nd serial edge of a status read.
// - R-event clears on status read, interval read, or after one data period; mode 11 never clears it.
// - Sample-sync clears on status read, or itself after a quarter period.
// - Sample-sync fires every 1st, 2nd, 4th or 16th sample instant.
// - Clear modes and sync rate live in read/write register 0x04.
// - Flags sit at bits 21, 20, 11, 10, 9 and 8.
// - Sample-sync is raised on the base-rate sample instant, decimated.
module iem_manager #(
    parameter int DATA_RATE = iem_pkg::DATA_RATE_CYCLES,
    parameter int QUARTER   = iem_pkg::QUARTER_CYCLES
) (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  iem_pkg::iem_xfer_s      xfer,
    output logic [23:0]             readData,
    input  wire logic               fastEngaged,
    input  wire logic               leadOffCond,
    input  wire logic               leadsOnCond,
    input  wire logic               pllUnlockCond,
    input  wire logic               rEventPulse,
    input  wire logic               sampleInstant,
    output logic [23:0]             statusFlags,
    output iem_pkg::iem_pin_s       primaryIrqN,
    output iem_pkg::iem_pin_s       secondaryIrqN
);
    // ========================================
    // Registers
    // ========================================
    logic [23:0] primaryEnable;
    logic [23:0] secondaryEnable;
    logic [23:0] management;
    logic        fastFlag;
    logic        fastArmed;
    logic        fastPrev;
    logic        leadOffFlag;
    logic        leadsOnFlag;
    logic        pllFlag;
    logic        rEventFlag;
    logic        syncFlag;
    logic [15:0] rEventTimer;
    logic [15:0] syncTimer;
    logic [3:0]  sampleCount;

    // ========================================
    // Decode; a transfer strobe marks the 32nd serial edge
    // ========================================
    wire logic statusRead   = xfer.rd && xfer.addr == iem_pkg::ADDR_STATUS;
    wire logic intervalRead = xfer.rd && xfer.addr == iem_pkg::ADDR_R_INTERVAL;
    wire logic wrPrimary    = xfer.wr && xfer.addr == iem_pkg::ADDR_PRIMARY_EN;
    wire logic wrSecondary  = xfer.wr && xfer.addr == iem_pkg::ADDR_SECONDARY_EN;
    wire logic wrManagement = xfer.wr && xfer.addr == iem_pkg::ADDR_MANAGEMENT;
    wire logic fastClrMode  = management[iem_pkg::POS_FAST_CLR];
    wire logic [1:0] revClr = management[iem_pkg::POS_REV_CLR +: 2];
    wire logic syncClrSelf  = management[iem_pkg::POS_SYNC_CLR];
    wire logic [1:0] syncRate = management[iem_pkg::POS_SYNC_RATE +: 2];
    wire logic fastRise     = fastEngaged && !fastPrev;
    wire logic [3:0] rateMask = (syncRate == 2'b00) ? 4'h0 :
                                (syncRate == 2'b01) ? 4'h1 :
                                (syncRate == 2'b10) ? 4'h3 : 4'hF;
    wire logic syncFire     = sampleInstant && ((sampleCount & rateMask) == 4'h0);
    wire logic revClrRead   = (revClr == 2'b00 && statusRead) ||
                              (revClr == 2'b01 && intervalRead);
    wire logic revTimeout   = revClr == 2'b10 && rEventTimer == 16'(DATA_RATE - 1);
    wire logic syncTimeout  = syncClrSelf && syncTimer == 16'(QUARTER - 1);

    assign statusFlags = {2'b00, fastFlag, leadOffFlag, 8'h00,
                          leadsOnFlag, rEventFlag, syncFlag, pllFlag, 8'h00};
    assign readData = (xfer.addr == iem_pkg::ADDR_PRIMARY_EN)   ? primaryEnable   :
                      (xfer.addr == iem_pkg::ADDR_SECONDARY_EN) ? secondaryEnable :
                      (xfer.addr == iem_pkg::ADDR_MANAGEMENT)   ? management      :
                      (xfer.addr == iem_pkg::ADDR_STATUS)       ? statusFlags     : 24'h000000;

    // ========================================
    // Configuration registers
    // ========================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            primaryEnable <= iem_pkg::EN_RESET;
        end else if (wrPrimary) begin
            primaryEnable <= xfer.data & iem_pkg::EN_MASK;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            secondaryEnable <= iem_pkg::EN_RESET;
        end else if (wrSecondary) begin
            secondaryEnable <= xfer.data & iem_pkg::EN_MASK;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            management <= iem_pkg::MNG_RESET;
        end else if (wrManagement) begin
            management <= xfer.data & iem_pkg::MNG_MASK;
        end
    end

    // ========================================
    // Level flags: held while the condition lasts, then until status read
    // ========================================
    wire logic next_leadOffFlag = leadOffCond   || (leadOffFlag && !statusRead);
    wire logic next_leadsOnFlag = leadsOnCond   || (leadsOnFlag && !statusRead);
    wire logic next_pllFlag     = pllUnlockCond || (pllFlag && !statusRead);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            leadOffFlag <= 1'b0;
            leadsOnFlag <= 1'b0;
            pllFlag     <= 1'b0;
        end else begin
            leadOffFlag <= next_leadOffFlag;
            leadsOnFlag <= next_leadsOnFlag;
            pllFlag     <= next_pllFlag;
        end
    end

    // ========================================
    // Fast-recovery flag
    // ========================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fastFlag  <= 1'b0;
            fastArmed <= 1'b1;
            fastPrev  <= 1'b0;
        end else begin
            fastPrev <= fastEngaged;
            if (!fastClrMode) begin
                fastFlag  <= fastEngaged || (fastFlag && !statusRead);
                fastArmed <= 1'b1;
            end else if (fastRise || (fastEngaged && fastArmed)) begin
                fastFlag  <= 1'b1;
                fastArmed <= 1'b0;
            end else begin
                fastFlag  <= fastFlag && !statusRead;
                fastArmed <= fastArmed || !fastEngaged;
            end
        end
    end

    // ========================================
    // R-event and sample-sync flags; a new event wins over any clear
    // ========================================
    wire logic        syncClrRead      = statusRead && !syncClrSelf;
    wire logic        next_rEventFlag  = rEventPulse ||
                                         (rEventFlag && !revClrRead && !revTimeout);
    wire logic [15:0] next_rEventTimer = (rEventPulse || !rEventFlag) ? 16'h0000 :
                                         rEventTimer + 16'h0001;
    wire logic        next_syncFlag    = syncFire ||
                                         (syncFlag && !syncClrRead && !syncTimeout);
    wire logic [15:0] next_syncTimer   = (syncFire || !syncFlag) ? 16'h0000 :
                                         syncTimer + 16'h0001;

    // ========================================
    // Sample counter; it counts at every rate so a rate change applies at the next instant
    // ========================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sampleCount <= 4'h0;
        end else if (sampleInstant) begin
            sampleCount <= sampleCount + 4'h1;
        end
    end

    // ========================================
    // R-event flag and its self-clear timer
    // ========================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rEventFlag  <= 1'b0;
            rEventTimer <= 16'h0000;
        end else begin
            rEventFlag  <= next_rEventFlag;
            rEventTimer <= next_rEventTimer;
        end
    end

    // ========================================
    // Sample-sync flag and its quarter-period timer
    // ========================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            syncFlag  <= 1'b0;
            syncTimer <= 16'h0000;
        end else begin
            syncFlag  <= next_syncFlag;
            syncTimer <= next_syncTimer;
        end
    end

    // ========================================
    // Pin drivers; masking leaves the flags themselves untouched
    // ========================================
    // Index 0 is the primary pin and index 1 the secondary pin
    wire logic [23:0]       pinEnable [2];
    wire iem_pkg::iem_pin_s pinState  [2];

    assign pinEnable[0]  = primaryEnable;
    assign pinEnable[1]  = secondaryEnable;
    assign primaryIrqN   = pinState[0];
    assign secondaryIrqN = pinState[1];

    for (genvar ch = 0; ch < 2; ch++) begin : g_pin
        // The low byte holds the driver type, so only flag bits 23:8 may request
        wire logic req = |(statusFlags & pinEnable[ch] & ~24'h0000FF);
        iem_pin_driver pinDriver (
            .mclk       (mclk),
            .rst        (rst),
            .request    (req),
            .driverType (pinEnable[ch][iem_pkg::POS_TYPE +: 2]),
            .pin        (pinState[ch])
        );
    end
endmodule : iem_manager

// ===== tb/iem_host_model.sv
// Host model: register transfers at the device's serial port
`timescale 1ns/1ps
module iem_host_model (
    input  wire logic          mclk,
    input  wire logic [23:0]   readData,
    output iem_pkg::iem_xfer_s xfer
);
    logic [23:0] rdHold;
    initial xfer = '0;
    // Read data is taken at the strobe edge, so a read-clear at that edge cannot leak in
    always_ff @(posedge mclk) rdHold <= readData;
    // One strobe cycle stands for the 32nd serial edge; the serial bits are not modelled
    task automatic access(input logic w, input logic [6:0] a, input logic [23:0] d,
                          output logic [23:0] q);
        @(negedge mclk);
        xfer <= '{w, !w, a, d};
        @(negedge mclk);
        q = rdHold;
        xfer <= '0;
    endtask : access
endmodule : iem_host_model

// ===== tb/iem_manager_asserts.sv
// Checker: port properties of the interrupt enable manager
`timescale 1ns/1ps
module iem_manager_asserts (
    input wire logic          mclk,
    input wire logic          rst,
    input iem_pkg::iem_xfer_s xfer,
    input wire logic [23:0]   readData,
    input wire logic          fastEngaged,
    input wire logic          leadOffCond,
    input wire logic          pllUnlockCond,
    input wire logic          rEventPulse,
    input wire logic [23:0]   statusFlags,
    input iem_pkg::iem_pin_s  primaryIrqN
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========
    // Helpers
    wire logic pLow  = primaryIrqN.oe & ~primaryIrqN.out;
    wire logic stsRd = xfer.rd && xfer.addr == 7'h01;
    wire logic wrPri = xfer.wr && xfer.addr == 7'h02;
    wire logic anyF  = |(statusFlags & 24'h300F00);
    // ==========
    // Properties
    property p_en_undef; xfer.addr inside {7'h02, 7'h03} |-> !(readData & 24'h0FF0FC); endproperty
    property p_mng_undef; xfer.addr == 7'h04 |-> !(readData & 24'hFFFF88); endproperty
    property p_sts_bits; !(statusFlags & 24'hCFF0FF); endproperty
    property p_lead_set; leadOffCond |=> statusFlags[20]; endproperty
    property p_pll_set; pllUnlockCond |=> statusFlags[8]; endproperty
    property p_rev_set; rEventPulse |=> statusFlags[10]; endproperty
    property p_rd_clr; stsRd && !leadOffCond |=> !statusFlags[20]; endproperty
    property p_fast_hold; statusFlags[21] && !fastEngaged && !stsRd |=> statusFlags[21]; endproperty
    property p_low_cause; pLow |-> $past(anyF) || $past(anyF, 2); endproperty
    property p_pp_idle; wrPri && xfer.data == 24'h000001 |-> ##[1:3] primaryIrqN.oe && primaryIrqN.out; endproperty
    property p_off; wrPri && xfer.data[1:0] == 2'b00 |-> ##[1:3] !primaryIrqN.oe; endproperty
    a_en_undef: assert property (p_en_undef) else $error("enable undefined bit set");
    a_mng_undef: assert property (p_mng_undef) else $error("manage undefined bit set");
    a_sts_bits: assert property (p_sts_bits) else $error("stray status bit");
    a_lead_set: assert property (p_lead_set) else $error("lead-off flag missing");
    a_pll_set: assert property (p_pll_set) else $error("pll flag missing");
    a_rev_set: assert property (p_rev_set) else $error("r-event flag missing");
    a_rd_clr: assert property (p_rd_clr) else $error("flag kept after read");
    a_fast_hold: assert property (p_fast_hold) else $error("fast flag dropped");
    a_low_cause: assert property (p_low_cause) else $error("pin low without flag");
    a_pp_idle: assert property (p_pp_idle) else $error("push-pull idle wrong");
    a_off: assert property (p_off) else $error("disabled pin driven");
    c_low: cover property (pLow);
    c_rd: cover property (stsRd && statusFlags[20]);
    c_sync: cover property (statusFlags[9]);
endmodule : iem_manager_asserts

// ===== tb/tb_top.sv
// Testbench: directed scenarios for the interrupt enable manager
`timescale 1ns/1ps
module tb_top;
    localparam logic [6:0] A_STS = iem_pkg::ADDR_STATUS;
    localparam logic [6:0] A_PRI = iem_pkg::ADDR_PRIMARY_EN;
    localparam logic [6:0] A_MNG = iem_pkg::ADDR_MANAGEMENT;
    localparam logic [6:0] A_RIV = iem_pkg::ADDR_R_INTERVAL;
    localparam int         RATE  = 16;
    logic               mclk = 0, rst = 1, rEventPulse = 0, sampleInstant = 0;
    logic [3:0]         cond = '0;
    logic [23:0]        readData, statusFlags, q;
    iem_pkg::iem_xfer_s xfer;
    iem_pkg::iem_pin_s  priPin, secPin;
    int                 num_errors = 0, checks = 0, hits;
    int                 bitOf[4] = '{8, 11, 20, 21};
    wire logic [1:0]    irqLow = {secPin.oe & ~secPin.out, priPin.oe & ~priPin.out};
    // Short data rate keeps the self-clear spans cheap to simulate
    iem_manager #(.DATA_RATE(RATE), .QUARTER(RATE / 4)) dut_u (.mclk, .rst, .xfer, .readData,
        .fastEngaged(cond[3]), .leadOffCond(cond[2]), .leadsOnCond(cond[1]),
        .pllUnlockCond(cond[0]), .rEventPulse, .sampleInstant, .statusFlags,
        .primaryIrqN(priPin), .secondaryIrqN(secPin));
    iem_host_model host_u (.mclk, .readData, .xfer);
    initial forever #20 mclk = ~mclk;
    // ==========
    // Helpers
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n); repeat (n) @(negedge mclk); endtask : tick
    task automatic wr(input logic [6:0] a, input logic [23:0] d); host_u.access(1, a, d, q); endtask : wr
    task automatic rx(input logic [6:0] a); host_u.access(0, a, 24'h0, q); tick(1); endtask : rx
    task automatic rd(input logic [6:0] a, input logic [23:0] e); rx(a); check(q, e); endtask : rd
    task automatic pulse(input bit s);
        if (s) rEventPulse = 1'b1; else sampleInstant = 1'b1;
        tick(1);
        {rEventPulse, sampleInstant} = 2'b00;
    endtask : pulse
    task automatic conclude;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    // ==========
    // Scenarios
    task automatic t_regs;
        rd(A_PRI, 24'h000003);
        rd(iem_pkg::ADDR_SECONDARY_EN, 24'h000003);
        rd(A_MNG, 24'h000004);
        rd(7'h7F, 24'h0);
        wr(A_PRI, 24'hFFFFFF);
        rd(A_PRI, 24'hF00F03);
        wr(A_MNG, 24'hFFFFFF);
        rd(A_MNG, 24'h000077);
    endtask : t_regs
    task automatic t_type;
        logic [2:0] e[4] = '{3'h0, 3'h4, 3'h4, 3'h5};
        cond[0] = 1'b1;
        for (int t = 0; t < 4; t++) begin
            wr(A_PRI, 24'h000100 | 24'(t));
            tick(3);
            check(24'({priPin.oe, priPin.oe & priPin.out, priPin.pull}), 24'(e[t]));
        end
        wr(A_PRI, 24'h000101);
        cond[0] = 1'b0;
        rx(A_STS);
        tick(3);
        check(24'({priPin.oe, priPin.out}), 24'h3);
    endtask : t_type
    task automatic t_route;
        for (int i = 0; i < 4; i++) begin
            wr(A_PRI, 24'h000001 | (24'h1 << bitOf[i]));
            wr(iem_pkg::ADDR_SECONDARY_EN, 24'h300F01 ^ (24'h1 << bitOf[i]));
            cond[i] = 1'b1;
            tick(3);
            check(24'(irqLow), 24'h1);
            wr(A_PRI, 24'h000001);
            tick(2);
            check(24'(irqLow), 24'h0);
            check(24'(statusFlags[bitOf[i]]), 24'h1);
            cond[i] = 1'b0;
            rx(A_STS);
        end
    endtask : t_route
    task automatic t_sync;
        int e[4] = '{16, 8, 4, 1};
        for (int r = 0; r < 4; r++) begin
            wr(A_MNG, 24'h000004 | 24'(r));
            hits = 0;
            repeat (16) begin
                pulse(0);
                if (statusFlags[9] === 1'b1) hits++;
                tick(7);
                check(24'(statusFlags[9]), 24'h0);
            end
            check(24'(hits), 24'(e[r]));
        end
        // Sync pulse on the secondary pin only, held until a status read
        wr(iem_pkg::ADDR_SECONDARY_EN, 24'h000201);
        wr(A_MNG, 24'h000000);
        pulse(0);
        tick(8);
        check(24'(statusFlags[9]), 24'h1);
        check(24'(irqLow), 24'h2);
        rx(A_STS);
        check(24'(statusFlags[9]), 24'h0);
        check(24'(irqLow), 24'h0);
    endtask : t_sync
    task automatic t_revent;
        for (int m = 0; m < 2; m++) begin
            wr(A_MNG, 24'(m << 4));
            pulse(1);
            rx(m ? A_STS : A_RIV);
            check(24'(statusFlags[10]), 24'h1);
            rx(m ? A_RIV : A_STS);
            check(24'(statusFlags[10]), 24'h0);
        end
        wr(A_MNG, 24'h000020);
        pulse(1);
        tick(RATE - 1);
        check(24'(statusFlags[10]), 24'h1);
        tick(1);
        check(24'(statusFlags[10]), 24'h0);
    endtask : t_revent
    task automatic t_fast;
        for (int m = 0; m < 2; m++) begin
            wr(A_MNG, 24'(m << 6));
            cond[3] = 1'b1;
            tick(2);
            rx(A_STS);
            check(24'(statusFlags[21]), 24'(m == 0));
            cond[3] = 1'b0;
            tick(2);
            check(24'(statusFlags[21]), 24'(m == 0));
            rx(A_STS);
            check(24'(statusFlags[21]), 24'h0);
        end
    endtask : t_fast
    initial begin
        tick(12);
        rst = 1'b0;
        check(24'(irqLow), 24'h0);
        t_regs;
        t_type;
        t_route;
        t_sync;
        t_revent;
        t_fast;
        conclude;
    end
    // Tests need about 715 cycles; the 10000-cycle limit, some fourteen times that, means a hang
    initial begin
        #400us;
        num_errors++;
        conclude;
    end
endmodule : tb_top
bind iem_manager iem_manager_asserts chk_u (.mclk, .rst, .xfer, .readData, .fastEngaged,
    .leadOffCond, .pllUnlockCond, .rEventPulse, .statusFlags, .primaryIrqN);
